// File: common/ulm_pkg.sv
`default_nettype none
package ulm_pkg;
   // register word indices; byte address is four times the index
   localparam logic [2:0] ULM_IDX_DATA    = 3'h0;
   localparam logic [2:0] ULM_IDX_IEN     = 3'h1;
   localparam logic [2:0] ULM_IDX_ISID    = 3'h2;
   localparam logic [2:0] ULM_IDX_FMT     = 3'h3;
   localparam logic [2:0] ULM_IDX_MDM     = 3'h4;
   localparam logic [2:0] ULM_IDX_LSTAT   = 3'h5;
   localparam logic [2:0] ULM_IDX_MSTAT   = 3'h6;
   localparam logic [2:0] ULM_IDX_SCRATCH = 3'h7;
   // serial_line_format fields
   localparam int ULM_FMT_STB   = 2;
   localparam int ULM_FMT_PEN   = 3;
   localparam int ULM_FMT_EPS   = 4;
   localparam int ULM_FMT_STICK = 5;
   localparam int ULM_FMT_BRK   = 6;
   localparam int ULM_FMT_DLS   = 7;
   // modem_line_control fields
   localparam int ULM_MDM_TRDY  = 0;
   localparam int ULM_MDM_RREQ  = 1;
   localparam int ULM_MDM_UOUT  = 2;
   localparam int ULM_MDM_GATE  = 3;
   localparam int ULM_MDM_LOOP  = 4;
   // interrupt enable fields
   localparam int ULM_IEN_RDA   = 0;
   localparam int ULM_IEN_THRE  = 1;
   localparam int ULM_IEN_RLS   = 2;
   localparam int ULM_IEN_MS    = 3;
   // sticky line error bits
   localparam int ULM_ERR_OE    = 0;
   localparam int ULM_ERR_PE    = 1;
   localparam int ULM_ERR_FE    = 2;
   localparam int ULM_ERR_BI    = 3;
   // reset values
   localparam logic [7:0]  ULM_FMT_RST  = 8'h00;
   localparam logic [4:0]  ULM_MDM_RST  = 5'h00;
   localparam logic [15:0] ULM_DIV_RST  = 16'h0001;
   localparam logic [2:0]  ULM_PINS_RST = 3'h7;
   // interrupt identification codes
   localparam logic [3:0] ULM_IID_NONE = 4'h1;
   localparam logic [3:0] ULM_IID_RLS  = 4'h6;
   localparam logic [3:0] ULM_IID_RDA  = 4'h4;
   localparam logic [3:0] ULM_IID_CTO  = 4'hC;
   localparam logic [3:0] ULM_IID_THRE = 4'h2;
   localparam logic [3:0] ULM_IID_MS   = 4'h0;
   // timing in 16x baud ticks
   localparam int         ULM_OVS        = 16;
   localparam int         ULM_TOUT_CHARS = 4;
   localparam logic [3:0] ULM_OS_MID     = 4'h7;
   localparam logic [3:0] ULM_OS_LAST    = 4'hF;
   localparam logic [5:0] ULM_STOP1_LAST = 6'h0F;
   localparam logic [5:0] ULM_STOPH_LAST = 6'h17;
   localparam logic [5:0] ULM_STOP2_LAST = 6'h1F;
   localparam logic [3:0] ULM_BASE_BITS  = 4'h7;
   // receive queue
   localparam logic [4:0] ULM_RXQ_FULL  = 5'h10;
   localparam logic [4:0] ULM_TRIG_L0   = 5'h01;
   localparam logic [4:0] ULM_TRIG_L1   = 5'h04;
   localparam logic [4:0] ULM_TRIG_L2   = 5'h08;
   localparam logic [4:0] ULM_TRIG_L3   = 5'h0E;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
                             TX_STOP} ulm_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
                             RX_STOP} ulm_rx_t;
   typedef struct packed {
      logic clear_to_send_n;
      logic set_ready_n;
      logic ring_indicator_n;
      logic carrier_detect_n;
   } ulm_modem_in_t;
   typedef struct packed {
      logic txd;
      logic terminal_ready_n;
      logic send_request_n;
   } ulm_line_out_t;
   typedef struct packed {
      logic [7:0]       fmt;
      logic [4:0]       mdm;
      logic [3:0]       ier;
      logic [7:0]       scr;
      logic [15:0]      div;
      logic [15:0]      bcnt;
      logic             fcr_en;
      logic [1:0]       trig;
      logic [7:0]       thr;
      logic             thr_full;
      logic             thre_ip;
      ulm_tx_t          tx;
      logic [7:0]       tx_sh;
      logic [5:0]       tx_os;
      logic [2:0]       tx_bit;
      logic             tx_par;
      ulm_rx_t          rx;
      logic [7:0]       rx_sh;
      logic [3:0]       rx_os;
      logic [2:0]       rx_bit;
      logic             rx_pe;
      logic             rx_pb;
      logic             rx_prev;
      logic [15:0][7:0] rxq;
      logic [3:0]       rq_rd;
      logic [3:0]       rq_wr;
      logic [4:0]       rq_cnt;
      logic [9:0]       tout;
      logic             cto;
      logic [3:0]       lsr_err;
      logic [3:0]       ms_prev;
      logic             ms_ok;
      logic [3:0]       ms_d;
      logic [7:0]       rdata;
      logic [3:0]       snap;
      ulm_line_out_t    pins;
   } ulm_state_t;
endpackage : ulm_pkg
`default_nettype wire

// File: design/ulm_serial_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - interrupt id bits 4 and 5 always read as zero.
// R2 - interrupt id bits 6 and 7 read one when FIFO mode is on.
// R3 - id code encodes highest pending source in fixed priority order.
// R4 - FIFO mode timeout after four idle character times with data held.
// R5 - transmit-empty interrupt cleared by id read or holding write.
// R6 - format bits 1:0 select five to eight data bits.
// R7 - format bit 2 gives two stop bits, 1.5 for five-bit words.
// R8 - receiver checks only the first stop bit.
// R9 - format bit 3 adds and checks a parity bit after data.
// R10 - format bit 4 selects even parity, clear gives odd.
// R11 - format bit 5 makes parity a fixed level opposite bit 4.
// R12 - format bit 6 holds transmit output low while set.
// R13 - format bit 7 switches offsets 0 and 1 to divisor latches.
// R14 - control bit 0 drives terminal ready pin inverted.
// R15 - control bit 1 drives send request pin inverted.
// R16 - control bit 2 is plain storage without a pin.
// R17 - control bit 3 enables the interrupt output driver.
// R18 - loopback marks transmit pin and feeds transmitter into receiver.
// R19 - loopback routes control bits to modem inputs, pins held high.
// R20 - loopback modem interrupts come from control bits, still enabled.
// R21 - control register bits 7:5 always read zero.
// R22 - id bit 0 reads zero when any enabled interrupt pends.
// R23 - id value stays frozen for the whole host read.
// R24 - timeout character time follows word, parity and stop settings.
////////////////////////////////////////////////////////////////////////////
module ulm_serial_ctrl
   import ulm_pkg::*;
(
   input  wire logic          sys_clk,   // system clock
   input  wire logic          sys_rst,   // synchronous reset, high
   input  wire logic          psel,      // apb select
   input  wire logic          penable,   // apb access phase
   input  wire logic          pwrite,    // apb write
   input  wire logic [11:0]   paddr,     // apb byte address
   input  wire logic [31:0]   pwdata,    // apb write data
   output logic      [31:0]   prdata,    // apb read data
   output logic               pready,    // apb ready
   output logic               pslverr,   // apb error
   input  wire logic          rxd,       // serial input
   input  wire ulm_modem_in_t modem_in,  // modem status pins
   output var ulm_line_out_t  line_out,  // serial and modem outputs
   output logic               irq,       // interrupt request
   output logic               irq_oe     // interrupt driver enable
);

   ulm_state_t s;
   ulm_state_t n;
   logic [2:0] idx;
   logic       bad;
   logic       setup;
   logic       wr;
   logic       rd;
   logic       isid_setup;
   logic       divisor_latch_select;
   logic       loop;
   logic       baud_tick;
   logic       serial;
   logic       rx_in;
   logic       pop;
   logic       push;
   logic       push_ok;
   logic       qfull;
   logic       flush;
   logic       rda;
   logic [2:0] wlast;
   logic [7:0] dmask;
   logic [5:0] stop_last;
   logic [5:0] tx_last;
   logic [3:0] nbits;
   logic [9:0] tlim;
   logic [4:0] trig_lvl;
   logic [3:0] iid;
   logic [3:0] msv;
   logic [7:0] lsr;

   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [7:0] m,
                                    input logic       ev,
                                    input logic       st);
      // R11 stick parity level
      if (st)
         par_bit = ~ev;
      // R10 odd or even
      else
         par_bit = (^(d & m)) ^ ~ev;
   endfunction : par_bit

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   assign idx        = paddr[4:2];
   assign bad        = (|paddr[11:5]) | (|paddr[1:0]);
   assign setup      = psel & ~penable;
   assign wr         = psel & penable & ~bad & pwrite;
   assign rd         = psel & penable & ~bad & ~pwrite;
   assign isid_setup = setup & ~pwrite & ~bad & (idx == ULM_IDX_ISID);
   assign pready     = 1'b1;
   assign pslverr    = psel & penable & bad;
   assign prdata     = {24'h000000, s.rdata};
   assign divisor_latch_select       = s.fmt[ULM_FMT_DLS];
   assign loop       = s.mdm[ULM_MDM_LOOP];
   assign line_out   = s.pins;
   // R17 interrupt driver gate
   assign irq_oe     = s.mdm[ULM_MDM_GATE];
   assign irq        = (iid != ULM_IID_NONE);

   ////////////////////////////////////////////////////////////////////////
   // character format

   assign baud_tick = (s.bcnt <= 16'h0001);
   // R6 word length end
   assign wlast = 3'h4 + {1'b0, s.fmt[1:0]};
   assign dmask = 8'hFF >> (2'h3 - s.fmt[1:0]);
   // R7 stop bit length
   assign stop_last = ~s.fmt[ULM_FMT_STB] ? ULM_STOP1_LAST :
                      (s.fmt[1:0] == 2'h0) ? ULM_STOPH_LAST :
                      ULM_STOP2_LAST;
   assign tx_last = (s.tx == TX_STOP) ? stop_last : {2'h0, ULM_OS_LAST};
   // R24 character time
   assign nbits = ULM_BASE_BITS + {2'h0, s.fmt[1:0]}
                + {3'h0, s.fmt[ULM_FMT_PEN]} + {3'h0, s.fmt[ULM_FMT_STB]};
   assign tlim  = 10'(nbits * ULM_OVS * ULM_TOUT_CHARS);

   always_comb begin
      case (s.tx)
         TX_START: serial = 1'b0;
         TX_DATA:  serial = s.tx_sh[0];
         TX_PAR:   serial = s.tx_par;
         default:  serial = 1'b1;
      endcase
      // R12 break forces spacing
      if (s.fmt[ULM_FMT_BRK])
         serial = 1'b0;
   end

   // R18 loop serial path
   assign rx_in = loop ? serial : rxd;
   // R19 loop modem inputs
   assign msv = loop ? {s.mdm[ULM_MDM_GATE], s.mdm[ULM_MDM_UOUT],
                        s.mdm[ULM_MDM_TRDY], s.mdm[ULM_MDM_RREQ]}
                     : ~{modem_in.carrier_detect_n,
                         modem_in.ring_indicator_n,
                         modem_in.set_ready_n,
                         modem_in.clear_to_send_n};

   ////////////////////////////////////////////////////////////////////////
   // receive queue and interrupt priority

   always_comb begin
      case (s.trig)
         2'h0:    trig_lvl = ULM_TRIG_L0;
         2'h1:    trig_lvl = ULM_TRIG_L1;
         2'h2:    trig_lvl = ULM_TRIG_L2;
         default: trig_lvl = ULM_TRIG_L3;
      endcase
   end

   assign rda     = s.fcr_en ? (s.rq_cnt >= trig_lvl) : (s.rq_cnt != 5'h00);
   assign qfull   = s.fcr_en ? (s.rq_cnt == ULM_RXQ_FULL)
                             : (s.rq_cnt != 5'h00);
   assign pop     = rd & (idx == ULM_IDX_DATA) & ~divisor_latch_select & (s.rq_cnt != 5'h00);
   assign push    = baud_tick & (s.rx == RX_STOP) & (s.rx_os == ULM_OS_MID);
   assign push_ok = push & (~qfull | pop);
   assign flush   = wr & (idx == ULM_IDX_ISID)
                  & ((pwdata[0] != s.fcr_en) | pwdata[1]);
   assign lsr = {s.fcr_en & (|s.lsr_err[3:1]),
                 ~s.thr_full & (s.tx == TX_IDLE),
                 ~s.thr_full, s.lsr_err, (s.rq_cnt != 5'h00)};

   always_comb begin
      // R3 priority encode
      if (s.ier[ULM_IEN_RLS] & (|s.lsr_err))
         iid = ULM_IID_RLS;
      else if (s.ier[ULM_IEN_RDA] & s.cto)
         iid = ULM_IID_CTO;
      else if (s.ier[ULM_IEN_RDA] & rda)
         iid = ULM_IID_RDA;
      else if (s.ier[ULM_IEN_THRE] & s.thre_ip)
         iid = ULM_IID_THRE;
      // R20 modem events stay enable gated
      else if (s.ier[ULM_IEN_MS] & (|s.ms_d))
         iid = ULM_IID_MS;
      else
         iid = ULM_IID_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      n = s;
      n.bcnt = baud_tick ? s.div : s.bcnt - 16'h0001;

      // R23 read value frozen at setup
      if (setup & ~pwrite & ~bad) begin
         n.snap = ULM_IID_NONE;
         case (idx)
            ULM_IDX_DATA:
               n.rdata = divisor_latch_select ? s.div[7:0] : s.rxq[s.rq_rd];
            ULM_IDX_IEN:
               n.rdata = divisor_latch_select ? s.div[15:8] : {4'h0, s.ier};
            ULM_IDX_ISID: begin
               // R1 R2 R22 identification byte
               n.rdata = {{2{s.fcr_en}}, 2'h0, iid};
               n.snap  = iid;
            end
            ULM_IDX_FMT:   n.rdata = s.fmt;
            // R21 upper control bits zero
            ULM_IDX_MDM:   n.rdata = {3'h0, s.mdm};
            ULM_IDX_LSTAT: n.rdata = lsr;
            ULM_IDX_MSTAT: n.rdata = {msv, s.ms_d};
            default:       n.rdata = s.scr;
         endcase
      end

      // read side effects; hardware sets below win
      if (rd & (idx == ULM_IDX_LSTAT))
         n.lsr_err = 4'h0;
      if (rd & (idx == ULM_IDX_MSTAT))
         n.ms_d = 4'h0;
      // R5 id read clears transmit empty
      if (rd & (idx == ULM_IDX_ISID) & (s.snap == ULM_IID_THRE))
         n.thre_ip = 1'b0;

      // transmitter
      case (s.tx)
         TX_IDLE: begin
            if (s.thr_full) begin
               n.tx       = TX_START;
               n.tx_sh    = s.thr;
               // R9 parity generated
               n.tx_par   = par_bit(s.thr, dmask, s.fmt[ULM_FMT_EPS],
                                    s.fmt[ULM_FMT_STICK]);
               n.tx_os    = 6'h00;
               n.thr_full = 1'b0;
               n.thre_ip  = 1'b1;
            end
         end
         TX_START, TX_DATA, TX_PAR, TX_STOP: begin
            if (baud_tick) begin
               n.tx_os = s.tx_os + 6'h01;
               if (s.tx_os == tx_last) begin
                  n.tx_os = 6'h00;
                  if (s.tx == TX_START) begin
                     n.tx     = TX_DATA;
                     n.tx_bit = 3'h0;
                  end else if (s.tx == TX_DATA) begin
                     n.tx_sh  = s.tx_sh >> 1;
                     n.tx_bit = s.tx_bit + 3'h1;
                     if (s.tx_bit == wlast)
                        n.tx = s.fmt[ULM_FMT_PEN] ? TX_PAR : TX_STOP;
                  end else if (s.tx == TX_PAR) begin
                     n.tx = TX_STOP;
                  end else begin
                     n.tx = TX_IDLE;
                  end
               end
            end
         end
         default: n.tx = TX_IDLE;
      endcase

      // receiver
      if (baud_tick)
         n.rx_prev = rx_in;
      if (baud_tick) begin
         case (s.rx)
            RX_IDLE: begin
               if (s.rx_prev & ~rx_in) begin
                  n.rx     = RX_START;
                  n.rx_os  = 4'h0;
                  n.rx_sh  = 8'h00;
                  n.rx_bit = 3'h0;
                  n.rx_pe  = 1'b0;
                  n.rx_pb  = 1'b0;
               end
            end
            RX_START: begin
               n.rx_os = s.rx_os + 4'h1;
               if ((s.rx_os == ULM_OS_MID) & rx_in)
                  n.rx = RX_IDLE;
               else if (s.rx_os == ULM_OS_LAST)
                  n.rx = RX_DATA;
            end
            RX_DATA: begin
               n.rx_os = s.rx_os + 4'h1;
               if (s.rx_os == ULM_OS_MID)
                  n.rx_sh[s.rx_bit] = rx_in;
               if (s.rx_os == ULM_OS_LAST) begin
                  n.rx_bit = s.rx_bit + 3'h1;
                  if (s.rx_bit == wlast)
                     n.rx = s.fmt[ULM_FMT_PEN] ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: begin
               n.rx_os = s.rx_os + 4'h1;
               // R9 R10 R11 parity checked
               if (s.rx_os == ULM_OS_MID) begin
                  n.rx_pb = rx_in;
                  n.rx_pe = rx_in ^ par_bit(s.rx_sh, dmask,
                                            s.fmt[ULM_FMT_EPS],
                                            s.fmt[ULM_FMT_STICK]);
               end
               if (s.rx_os == ULM_OS_LAST)
                  n.rx = RX_STOP;
            end
            RX_STOP: begin
               n.rx_os = s.rx_os + 4'h1;
               // R8 only first stop bit sampled
               if (s.rx_os == ULM_OS_MID)
                  n.rx = RX_IDLE;
            end
            default: n.rx = RX_IDLE;
         endcase
      end
      if (push) begin
         if (~rx_in)
            n.lsr_err[ULM_ERR_FE] = 1'b1;
         if (~rx_in & (s.rx_sh == 8'h00) & ~s.rx_pb)
            n.lsr_err[ULM_ERR_BI] = 1'b1;
         if (s.rx_pe)
            n.lsr_err[ULM_ERR_PE] = 1'b1;
      end

      // R20 modem change detection
      n.ms_prev = msv;
      n.ms_ok   = 1'b1;
      if (s.ms_ok)
         n.ms_d = n.ms_d | {msv[3] ^ s.ms_prev[3], s.ms_prev[2] & ~msv[2],
                            msv[1] ^ s.ms_prev[1], msv[0] ^ s.ms_prev[0]};

      // R13 divisor select decode
      if (wr) begin
         case (idx)
            ULM_IDX_DATA: begin
               if (divisor_latch_select) begin
                  n.div[7:0] = pwdata[7:0];
                  n.bcnt     = {s.div[15:8], pwdata[7:0]};
               end else begin
                  n.thr      = pwdata[7:0];
                  n.thr_full = 1'b1;
                  // R5 holding write clears
                  n.thre_ip  = 1'b0;
               end
            end
            ULM_IDX_IEN: begin
               if (divisor_latch_select) begin
                  n.div[15:8] = pwdata[7:0];
                  n.bcnt      = {pwdata[7:0], s.div[7:0]};
               end else begin
                  n.ier = pwdata[3:0];
                  if (~s.ier[ULM_IEN_THRE] & pwdata[ULM_IEN_THRE]
                      & ~s.thr_full)
                     n.thre_ip = 1'b1;
               end
            end
            ULM_IDX_ISID: begin
               n.fcr_en = pwdata[0];
               n.trig   = pwdata[7:6];
            end
            ULM_IDX_FMT:     n.fmt = pwdata[7:0];
            // R16 storage bit kept in register
            ULM_IDX_MDM:     n.mdm = pwdata[4:0];
            ULM_IDX_SCRATCH: n.scr = pwdata[7:0];
            default: ;
         endcase
      end

      // receive queue
      if (flush) begin
         n.rq_rd  = 4'h0;
         n.rq_wr  = 4'h0;
         n.rq_cnt = 5'h00;
      end else begin
         if (pop)
            n.rq_rd = s.rq_rd + 4'h1;
         if (push_ok) begin
            n.rxq[s.rq_wr] = s.rx_sh;
            n.rq_wr        = s.rq_wr + 4'h1;
         end else if (push & ~s.fcr_en) begin
            n.rxq[s.rq_rd] = s.rx_sh;
         end
         if (push & qfull & ~pop)
            n.lsr_err[ULM_ERR_OE] = 1'b1;
         n.rq_cnt = s.rq_cnt + {4'h0, push_ok} - {4'h0, pop};
      end

      // R4 character timeout
      if (~n.fcr_en | (n.rq_cnt == 5'h00) | push | pop)
         n.tout = 10'h000;
      else if (baud_tick & (s.tout != tlim))
         n.tout = s.tout + 10'h001;
      if (pop | (n.rq_cnt == 5'h00) | ~n.fcr_en)
         n.cto = 1'b0;
      else if (s.tout == tlim)
         n.cto = 1'b1;

      // R14 R15 R18 R19 output pins
      n.pins.txd              = loop | serial;
      n.pins.terminal_ready_n = loop | ~s.mdm[ULM_MDM_TRDY];
      n.pins.send_request_n   = loop | ~s.mdm[ULM_MDM_RREQ];
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s      <= '0;
         s.fmt  <= ULM_FMT_RST;
         s.mdm  <= ULM_MDM_RST;
         s.div  <= ULM_DIV_RST;
         s.snap <= ULM_IID_NONE;
         s.pins <= ULM_PINS_RST;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   chk_iid_zero_bits: assert property ( // R1
      @(posedge sys_clk) disable iff (sys_rst)
      isid_setup |=> prdata[5:4] == 2'h0)
      else $error("id bits 5:4 not zero");

   chk_iid_fifo_bits: assert property ( // R2
      @(posedge sys_clk) disable iff (sys_rst)
      isid_setup |=> prdata[7:6] == {2{$past(s.fcr_en)}})
      else $error("id bits 7:6 do not follow fifo enable");

   chk_iid_priority: assert property ( // R3
      @(posedge sys_clk) disable iff (sys_rst)
      (iid == ULM_IID_THRE) |-> !(s.cto && s.ier[ULM_IEN_RDA])
         && !(s.ier[ULM_IEN_RLS] && (|s.lsr_err)))
      else $error("lower source reported over higher");

   chk_iid_pending: assert property ( // R22
      @(posedge sys_clk) disable iff (sys_rst)
      isid_setup |=> prdata[0] == !$past(irq))
      else $error("id bit 0 disagrees with pending state");

   chk_cto_data: assert property ( // R4
      @(posedge sys_clk) disable iff (sys_rst)
      s.cto |-> s.fcr_en && (s.rq_cnt != 5'h00))
      else $error("timeout without queued data");

   chk_thre_clear: assert property ( // R5
      @(posedge sys_clk) disable iff (sys_rst)
      wr && (idx == ULM_IDX_DATA) && !divisor_latch_select |=> !s.thre_ip && s.thr_full)
      else $error("holding write did not clear empty flag");

   chk_break_hold: assert property ( // R12
      @(posedge sys_clk) disable iff (sys_rst)
      s.fmt[ULM_FMT_BRK] && !loop |=> !line_out.txd)
      else $error("break did not hold transmit low");

   chk_ready_pins: assert property ( // R14
      @(posedge sys_clk) disable iff (sys_rst)
      !loop |=> line_out.terminal_ready_n == !$past(s.mdm[ULM_MDM_TRDY])
         && line_out.send_request_n == !$past(s.mdm[ULM_MDM_RREQ]))
      else $error("modem pins do not follow control bits");

   chk_loop_pins: assert property ( // R18
      @(posedge sys_clk) disable iff (sys_rst)
      loop |=> line_out.txd && line_out.terminal_ready_n
         && line_out.send_request_n)
      else $error("loopback pins not held high");

   chk_mdm_read_zero: assert property ( // R21
      @(posedge sys_clk) disable iff (sys_rst)
      setup && !pwrite && !bad && (idx == ULM_IDX_MDM)
         |=> prdata[7:5] == 3'h0)
      else $error("control bits 7:5 read nonzero");

endmodule : ulm_serial_ctrl
`default_nettype wire

// File: tb/uart_line_modem_interrupt_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module uart_line_modem_interrupt_ctrl_tb_top import ulm_pkg::*;;
   logic          sys_clk = 0, sys_rst = 1, psel = 0, penable = 0;
   logic          pwrite = 0, pready, pslverr, rxd, irq, irq_oe, err;
   logic [11:0]   paddr = '0;
   logic [31:0]   pwdata = '0, prdata, rd;
   ulm_modem_in_t modem_in;
   ulm_line_out_t line_out;
   int            n_fail = 0, checks = 0, k;
   always #5 sys_clk = ~sys_clk;
   ulm_modem_model u_mdm (.sys_clk(sys_clk), .line_out(line_out), .rxd(rxd),
      .modem_in(modem_in));
   ulm_serial_ctrl DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
      .modem_in(modem_in), .line_out(line_out), .irq(irq), .irq_oe(irq_oe));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      if (n_fail == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // one apb transfer, held until pready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
      int i;
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h000000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_fail++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   function automatic logic [11:0] ba(input logic [2:0] i);
      return {7'h00, i, 2'h0};
   endfunction : ba
   task automatic wr(input logic [2:0] i, input logic [7:0] d);
      xfer(1'b1, ba(i), d);
   endtask : wr
   task automatic rdc(input logic [2:0] i, input logic [31:0] e);
      xfer(1'b0, ba(i), 8'h00);
      chk(rd, e);
   endtask : rdc
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rdc(ULM_IDX_MDM, 32'h00);
      rdc(ULM_IDX_ISID, 32'h01);
      wr(ULM_IDX_MDM, 8'hEF);
      rdc(ULM_IDX_MDM, 32'h0F);
      chk({line_out[1:0], irq_oe}, 3'h1);
      wr(ULM_IDX_FMT, 8'h43);
      rdc(ULM_IDX_FMT, 32'h43);
      chk(line_out.txd, 1'b0);
      wr(ULM_IDX_FMT, 8'h83);
      repeat (2) @(posedge sys_clk);
      chk(line_out.txd, 1'b1);
      wr(ULM_IDX_MDM, 8'h1F);
      rdc(ULM_IDX_MSTAT, 32'hFB);
      chk(rd[7:4], 4'hF);
      chk(line_out, 3'h7);
      wr(ULM_IDX_DATA, 8'h01);
      wr(ULM_IDX_IEN, 8'h00);
      wr(ULM_IDX_FMT, 8'h03);
      wr(ULM_IDX_ISID, 8'h01);
      rdc(ULM_IDX_ISID, 32'hC1);
      wr(ULM_IDX_DATA, 8'hA5);
      rd = '0;
      for (k = 0; k < 200 && rd[0] !== 1'b1; k++)
         xfer(1'b0, ba(ULM_IDX_LSTAT), 8'h00);
      if (rd[0] !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
      rdc(ULM_IDX_DATA, 32'hA5);
      wr(ULM_IDX_IEN, 8'h02);
      @(posedge sys_clk);
      chk(irq, 1'b1);
      rdc(ULM_IDX_ISID, 32'hC2);
      rdc(ULM_IDX_ISID, 32'hC1);
      chk(irq, 1'b0);
      wr(ULM_IDX_FMT, 8'h83);
      rdc(ULM_IDX_IEN, 32'h00);
      wr(ULM_IDX_FMT, 8'h03);
      rdc(ULM_IDX_IEN, 32'h02);
      xfer(1'b0, 12'h020, 8'h00);
      chk(err, 1'b1);
      print_verdict();
   end
endmodule : uart_line_modem_interrupt_ctrl_tb_top
`default_nettype wire

// File: tb/ulm_modem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ulm_modem_model
   import ulm_pkg::*;
(
   input  wire logic          sys_clk,   // device clock
   input  wire ulm_line_out_t line_out,  // serial and modem outputs
   output var logic           rxd,       // serial line, idle marking
   output var ulm_modem_in_t  modem_in   // status lines, active low
);
   // null-modem cable: ready and request looped back, line held marking
   always_ff @(posedge sys_clk) begin
      rxd                       <= 1'b1;
      modem_in.clear_to_send_n  <= line_out.send_request_n;
      modem_in.set_ready_n      <= line_out.terminal_ready_n;
      modem_in.carrier_detect_n <= line_out.terminal_ready_n;
      modem_in.ring_indicator_n <= 1'b1;
   end
endmodule : ulm_modem_model
`default_nettype wire
